// ### core/iac_pkg.sv
/*
  Constants for the imager front-end control register bank: addresses,
  field positions, write masks, reset values and the channel encoding.
  Assumes a single synchronous clock domain and a parallel write/read
  port fed by the three-wire serial front end.
*/
// Operation
// R01: Host writes zero to mode bits 8,1,0
// R02: Mode bit 6 enables internal reference
// R03: Mode bit 5 picks three or one channel
// R04: Mode bit 4 picks double sampling or hold
// R05: Mode bit 3 picks 4 V or 3 V clamp
// R06: Mode bit 2 sleeps, registers kept
// R07: Host writes zero to order bits 8,3..0
// R08: Order bit 7 set steps red-green-blue
// R09: Order bit 7 clear steps blue-green-red
// R10: Order bits 6..4 pick single channel
// R11: Single channel never advances
// R12: Gain bits 8..6 zero, 6-bit code
// R13: Gain code is plain unsigned binary
// R14: Offset is 9-bit code, resets zero
// R15: Offset sign-magnitude, bit 8 sign
// R16: Host sets all registers via serial port
// R17: Three-channel steps on converter clock falls
// R18: Address 0 mode,1 order,2-4 gain,5-7 offset
// R19: Mode bit 7 reserved, kept zero
package iac_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned GAIN_W = 6;
  localparam int unsigned MAG_W  = 8;
  localparam int unsigned NUM_REGS = 8;

  // Register addresses
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_ORDER  = 3'h1;
  localparam logic [2:0] ADDR_GAIN_R = 3'h2;
  localparam logic [2:0] ADDR_OFS_R  = 3'h5;

  // Mode field positions
  localparam int unsigned MODE_VREF_BIT  = 6;
  localparam int unsigned MODE_THREE_BIT = 5;
  localparam int unsigned MODE_CDS_BIT   = 4;
  localparam int unsigned MODE_CLAMP_BIT = 3;
  localparam int unsigned MODE_SLEEP_BIT = 2;

  // Order field positions and the offset sign bit
  localparam int unsigned ORDER_RGB_BIT   = 7;
  localparam int unsigned ORDER_RED_BIT   = 6;
  localparam int unsigned ORDER_GREEN_BIT = 5;
  localparam int unsigned ORDER_BLUE_BIT  = 4;
  localparam int unsigned OFS_SIGN_BIT    = 8;

  // Writable bits; all others are stored as zero
  localparam logic [8:0] MODE_WMASK  = 9'h07C;
  localparam logic [8:0] ORDER_WMASK = 9'h0F0;
  localparam logic [8:0] GAIN_WMASK  = 9'h03F;
  localparam logic [8:0] OFS_WMASK   = 9'h1FF;

  // Power-on values
  localparam logic [8:0] MODE_RST  = 9'h078;
  localparam logic [8:0] ORDER_RST = 9'h0C0;
  localparam logic [8:0] GAIN_RST  = 9'h000;
  localparam logic [8:0] OFS_RST   = 9'h000;

  typedef enum logic [1:0] {
    CH_RED   = 2'b00,
    CH_GREEN = 2'b01,
    CH_BLUE  = 2'b10
  } iac_chan_e;
endpackage

// ### core/iac_regs.sv
/*
  Control register bank of the three-channel imager front end, with
  the converter channel sequencer and per-channel gain/offset select.
  Assumes the serial front end delivers one-cycle write strobes with
  address and data, and that the sample and converter clock events
  arrive as one-cycle pulses synchronous to sys_clk.
*/
`timescale 1ns/1ps
module iac_regs (
  input  wire logic       sys_clk,          // 40 MHz system clock
  input  wire logic       rst_n,            // Async reset, active low
  input  wire logic       wrEn,             // Register write strobe
  input  wire logic [2:0] wrAddr,           // Write address
  input  wire logic [8:0] wrData,           // Write data
  input  wire logic [2:0] rdAddr,           // Read address
  output logic      [8:0] rdData,           // Read data, registered
  input  wire logic       secondSampleClock, // Sample pulse, restart
  input  wire logic       converterClockFall, // Converter fall pulse
  output logic            intRefEnable,     // Internal reference on
  output logic            threeChannel,     // Three-channel mode
  output logic            cdsMode,          // Double sampling mode
  output logic            clampHigh,        // 4 V clamp bias
  output logic            sleepMode,        // Low-power sleep
  output logic      [1:0] activeChan,       // Channel on converter
  output logic      [5:0] chanGain,         // Gain of active channel
  output logic      [8:0] chanOffset        // Two's-complement offset
);

  // Reset release through two flops
  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Write mask per address
  function automatic logic [8:0] wrMask(input logic [2:0] a);
    if (a == iac_pkg::ADDR_MODE)
      wrMask = iac_pkg::MODE_WMASK;   // see R01 see R19
    else if (a == iac_pkg::ADDR_ORDER)
      wrMask = iac_pkg::ORDER_WMASK;  // see R07
    else if (a < iac_pkg::ADDR_OFS_R)
      wrMask = iac_pkg::GAIN_WMASK;   // see R12
    else
      wrMask = iac_pkg::OFS_WMASK;    // see R14
  endfunction

  // Power-on value per address
  function automatic logic [8:0] rstVal(input logic [2:0] a);
    if (a == iac_pkg::ADDR_MODE)
      rstVal = iac_pkg::MODE_RST;
    else if (a == iac_pkg::ADDR_ORDER)
      rstVal = iac_pkg::ORDER_RST;
    else if (a < iac_pkg::ADDR_OFS_R)
      rstVal = iac_pkg::GAIN_RST;
    else
      rstVal = iac_pkg::OFS_RST;
  endfunction

  // Sign-magnitude to two's complement; both zeros give zero
  function automatic logic [8:0] smToTc(input logic [8:0] c);
    logic [8:0] mag;
    mag = {1'b0, c[iac_pkg::MAG_W-1:0]};
    if (c[iac_pkg::OFS_SIGN_BIT])
      smToTc = 9'h000 - mag;          // see R15
    else
      smToTc = mag;
  endfunction

  // Register file state
  logic [8:0] regs_r   [iac_pkg::NUM_REGS];
  logic [8:0] regs_nxt [iac_pkg::NUM_REGS];
  logic [8:0] rdData_r;
  logic [8:0] rdData_nxt;

  // Writes land in one register; sleep keeps contents untouched
  always_comb begin
    for (int i = 0; i < iac_pkg::NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
      if (wrEn && wrAddr == 3'(i))
        regs_nxt[i] = wrData & wrMask(3'(i)); // see R18 see R06
    end
    rdData_nxt = regs_r[rdAddr];                // see R18
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < iac_pkg::NUM_REGS; i++)
        regs_r[i] <= rstVal(3'(i));
      rdData_r <= 9'h000;
    end else if (!rstSync_r) begin
      for (int i = 0; i < iac_pkg::NUM_REGS; i++)
        regs_r[i] <= rstVal(3'(i));
      rdData_r <= 9'h000;
    end else begin
      for (int i = 0; i < iac_pkg::NUM_REGS; i++)
        regs_r[i] <= regs_nxt[i];
      rdData_r <= rdData_nxt;
    end
  end

  // Mode fields straight from the stored register
  logic [8:0] modeReg;
  logic [8:0] orderReg;
  assign modeReg      = regs_r[iac_pkg::ADDR_MODE];
  assign orderReg     = regs_r[iac_pkg::ADDR_ORDER];
  assign intRefEnable = modeReg[iac_pkg::MODE_VREF_BIT];  // see R02
  assign threeChannel = modeReg[iac_pkg::MODE_THREE_BIT]; // see R03
  assign cdsMode      = modeReg[iac_pkg::MODE_CDS_BIT];   // see R04
  assign clampHigh    = modeReg[iac_pkg::MODE_CLAMP_BIT]; // see R05
  assign sleepMode    = modeReg[iac_pkg::MODE_SLEEP_BIT]; // see R06
  assign rdData       = rdData_r;

  // Channel sequencer
  iac_pkg::iac_chan_e chan_r;
  iac_pkg::iac_chan_e chan_nxt;
  iac_pkg::iac_chan_e firstChan;
  iac_pkg::iac_chan_e singleChan;
  logic [5:0] gain_r;
  logic [5:0] gain_nxt;
  logic [8:0] ofs_r;
  logic [8:0] ofs_nxt;
  logic       fwdOrder;

  assign fwdOrder = orderReg[iac_pkg::ORDER_RGB_BIT];

  // First channel of a pass; priority red, green, blue if several single bits set
  always_comb begin
    firstChan = fwdOrder ? iac_pkg::CH_RED
                         : iac_pkg::CH_BLUE;   // see R08 see R09
    if (orderReg[iac_pkg::ORDER_RED_BIT])
      singleChan = iac_pkg::CH_RED;            // see R10
    else if (orderReg[iac_pkg::ORDER_GREEN_BIT])
      singleChan = iac_pkg::CH_GREEN;
    else if (orderReg[iac_pkg::ORDER_BLUE_BIT])
      singleChan = iac_pkg::CH_BLUE;
    else
      singleChan = iac_pkg::CH_RED;
  end

  // Sample pulse beats a converter fall in the same cycle; the
  // three-channel sequencer freezes in sleep since the converter is idle then
  always_comb begin
    chan_nxt = chan_r;
    if (!threeChannel) begin
      chan_nxt = singleChan;                   // see R11
    end else if (sleepMode) begin
      chan_nxt = chan_r;
    end else if (secondSampleClock) begin
      chan_nxt = firstChan;                    // see R08 see R09
    end else if (converterClockFall) begin     // see R17
      unique case (chan_r)
        iac_pkg::CH_RED:
          chan_nxt = fwdOrder ? iac_pkg::CH_GREEN : iac_pkg::CH_BLUE;
        iac_pkg::CH_GREEN:
          chan_nxt = fwdOrder ? iac_pkg::CH_BLUE : iac_pkg::CH_RED;
        iac_pkg::CH_BLUE:
          chan_nxt = fwdOrder ? iac_pkg::CH_RED : iac_pkg::CH_GREEN;
        default:
          chan_nxt = firstChan;
      endcase
    end
    // Gain and offset follow the channel and any write this cycle
    gain_nxt = regs_nxt[iac_pkg::ADDR_GAIN_R + {1'b0, chan_nxt}]
               [iac_pkg::GAIN_W-1:0];          // see R13
    ofs_nxt  = smToTc(regs_nxt[iac_pkg::ADDR_OFS_R + {1'b0, chan_nxt}]);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_r <= iac_pkg::CH_RED;
      gain_r <= 6'h00;
      ofs_r  <= 9'h000;
    end else if (!rstSync_r) begin
      chan_r <= iac_pkg::CH_RED;
      gain_r <= 6'h00;
      ofs_r  <= 9'h000;
    end else begin
      chan_r <= chan_nxt;
      gain_r <= gain_nxt;
      ofs_r  <= ofs_nxt;
    end
  end

  assign activeChan = chan_r;
  assign chanGain   = gain_r;
  assign chanOffset = ofs_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync_r);

  logic run3;
  assign run3 = threeChannel && !sleepMode;

  sequence s_restart;
    run3 && secondSampleClock;
  endsequence

  sequence s_advance;
    run3 && !secondSampleClock && converterClockFall;
  endsequence

  a_restart_first: assert property ( // see R08 see R09
    s_restart |=> chan_r == (($past(fwdOrder)) ? iac_pkg::CH_RED
                                               : iac_pkg::CH_BLUE))
    else $error("sample pulse did not restart the pass");

  a_rgb_walk: assert property ( // see R08
    (s_restart and fwdOrder && !wrEn) ##1 (s_advance and !wrEn)
      |=> chan_r == iac_pkg::CH_GREEN)
    else $error("forward order second step not green");

  a_bgr_step: assert property ( // see R09
    s_advance and (!fwdOrder && chan_r == iac_pkg::CH_BLUE)
      |=> chan_r == iac_pkg::CH_GREEN)
    else $error("reverse order did not go blue to green");

  // An order write shows one cycle late, so the quiet cycle comes first
  a_single_hold: assert property ( // see R11
    !threeChannel && !wrEn ##1 !threeChannel
      |=> $stable(chan_r))
    else $error("single channel moved");

  a_single_pick: assert property ( // see R10
    !threeChannel && orderReg[iac_pkg::ORDER_GREEN_BIT]
      && !orderReg[iac_pkg::ORDER_RED_BIT] && !wrEn
      |=> chan_r == iac_pkg::CH_GREEN)
    else $error("single green select ignored");

  a_reserved_zero: assert property ( // see R01 see R07 see R19
    wrEn |=> (regs_r[$past(wrAddr)] & ~wrMask($past(wrAddr))) == 9'h000)
    else $error("reserved bit stored as one");

  a_mode_write: assert property ( // see R06
    wrEn && wrAddr == iac_pkg::ADDR_MODE
      |=> sleepMode == $past(wrData[iac_pkg::MODE_SLEEP_BIT])
          && threeChannel == $past(wrData[iac_pkg::MODE_THREE_BIT]))
    else $error("mode write not applied");

  a_regs_hold: assert property ( // see R06
    !wrEn |=> regs_r[iac_pkg::ADDR_GAIN_R] ==
               $past(regs_r[iac_pkg::ADDR_GAIN_R]))
    else $error("gain register changed without write");

  a_gain_follow: assert property ( // see R13
    1'b1 |=> chanGain == regs_r[iac_pkg::ADDR_GAIN_R + {1'b0, chan_r}]
                         [iac_pkg::GAIN_W-1:0])
    else $error("gain output not of active channel");

  a_offset_sign: assert property ( // see R15
    1'b1 |=> chanOffset == smToTc(regs_r[iac_pkg::ADDR_OFS_R
                                          + {1'b0, chan_r}]))
    else $error("offset conversion wrong");

  a_reset_value: assert property ( // see R02 see R03 see R04 see R05
    $rose(rstSync_r) |-> intRefEnable && threeChannel && cdsMode
                          && clampHigh && !sleepMode
                          && chanGain == 6'h00 && chanOffset == 9'h000)
    else $error("power-on defaults wrong");

  // Sleep in three-channel mode parks the sequencer on its channel
  a_sleep_freeze: assert property ( // see R06
    threeChannel && sleepMode |=> $stable(chan_r))
    else $error("sequencer moved in sleep");

  a_rgb_step: assert property ( // see R08
    s_advance and (fwdOrder && chan_r == iac_pkg::CH_GREEN)
      |=> chan_r == iac_pkg::CH_BLUE)
    else $error("forward order did not go green to blue");

  a_bgr_wrap: assert property ( // see R09
    s_advance and (!fwdOrder && chan_r == iac_pkg::CH_RED)
      |=> chan_r == iac_pkg::CH_BLUE)
    else $error("reverse order did not wrap red to blue");

  a_single_blue: assert property ( // see R10
    !threeChannel && orderReg[iac_pkg::ORDER_BLUE_BIT]
      && !orderReg[iac_pkg::ORDER_GREEN_BIT]
      && !orderReg[iac_pkg::ORDER_RED_BIT]
      |=> chan_r == iac_pkg::CH_BLUE)
    else $error("single blue select ignored");

  a_single_red: assert property ( // see R10
    !threeChannel && orderReg[iac_pkg::ORDER_RED_BIT]
      |=> chan_r == iac_pkg::CH_RED)
    else $error("single red select ignored");

  // Read data is the addressed register of the cycle before
  a_read_back: assert property ( // see R18
    1'b1 |=> rdData == $past(regs_r[rdAddr]))
    else $error("read data not of addressed register");

  a_bias_write: assert property ( // see R02 see R04 see R05
    wrEn && wrAddr == iac_pkg::ADDR_MODE
      |=> intRefEnable == $past(wrData[iac_pkg::MODE_VREF_BIT])
          && cdsMode == $past(wrData[iac_pkg::MODE_CDS_BIT])
          && clampHigh == $past(wrData[iac_pkg::MODE_CLAMP_BIT]))
    else $error("reference, sampling or clamp write not applied");

endmodule // iac_regs

// ### tb/iac_host_model.sv
/*
  Host controller model standing on the serial side of the register bank.
  It presents the parallel write strobe and the read address.
  Assumes that its tasks are called at a falling edge of sys_clk.
*/
`timescale 1ns/1ps
module iac_host_model (
  input  wire logic       sys_clk, // System clock
  output logic            wrEn,    // Write strobe
  output logic      [2:0] wrAddr,  // Write address
  output logic      [8:0] wrData,  // Write data
  output logic      [2:0] rdAddr,  // Read address
  input  wire logic [8:0] rdData   // Registered read data
);
  // Idle port from time zero
  initial begin
    wrEn = 1'b0;
    wrAddr = 3'h0;
    wrData = 9'h000;
    rdAddr = 3'h0;
  end

  // One-cycle write, then an idle cycle so the strobe never re-rises
  // within the time step in which it fell
  task automatic writeReg(input logic [2:0] a, input logic [8:0] v);
    wrAddr = a;
    wrData = v;
    wrEn = 1'b1;
    @(negedge sys_clk);
    wrEn = 1'b0;
    @(negedge sys_clk);
  endtask

  // Read data is valid one edge after the address is taken
  task automatic readReg(input logic [2:0] a, output logic [8:0] v);
    rdAddr = a;
    @(negedge sys_clk);
    v = rdData;
  endtask
endmodule // iac_host_model

// ### tb/imager_afe_control_registers_test.sv
/*
  Self-checking bench for the imager front-end control register bank.
  Assumes iac_pkg, iac_regs and iac_host_model are compiled first.
*/
`timescale 1ns/1ps
module imager_afe_control_registers_test;
  logic       sys_clk;            // 25 ns clock
  logic       rst_n;              // Active-low reset
  logic       wrEn;               // Write strobe
  logic [2:0] wrAddr;             // Write address
  logic [8:0] wrData;             // Write data
  logic [2:0] rdAddr;             // Read address
  logic [8:0] rdData;             // Read data
  logic       secondSampleClock;  // Pass restart pulse
  logic       converterClockFall; // Channel advance pulse
  logic [4:0] modePins;           // Mode outputs, bit 6 down to 2
  logic [1:0] activeChan;         // Channel on converter
  logic [5:0] chanGain;           // Gain of active channel
  logic [8:0] chanOffset;         // Offset of active channel
  logic [8:0] regModel [8];       // Expected register contents
  logic [8:0] d;                  // Read-back value
  int         ch;                 // Expected channel index
  int         badCount;           // Mismatches
  int         compares;           // Comparisons made
  int         cycles;             // Run length guard
  bit  [31:0] seed = 32'h0000004A; // Xorshift state
  logic [17:0] cfg [9] = '{18'h0F0C0, 18'h0F000, 18'h0F8C0, 18'h0B040,
    18'h0B020, 18'h0B010, 18'h0B000, 18'h0B030, 18'h0F080};

  iac_regs uut (.sys_clk, .rst_n, .wrEn, .wrAddr, .wrData, .rdAddr,
    .rdData, .secondSampleClock, .converterClockFall,
    .intRefEnable(modePins[4]), .threeChannel(modePins[3]),
    .cdsMode(modePins[2]), .clampHigh(modePins[1]),
    .sleepMode(modePins[0]), .activeChan, .chanGain, .chanOffset);

  iac_host_model host (.sys_clk, .wrEn, .wrAddr, .wrData, .rdAddr,
    .rdData);

  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      completeRun();
    end
  end

  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Writable bits per address; everything else reads back as zero
  function automatic logic [8:0] wmask(int a);
    return (a==0) ? 9'h07C : (a==1) ? 9'h0F0 : (a<5) ? 9'h03F : 9'h1FF;
  endfunction

  task automatic chkReg(logic [8:0] e, logic [8:0] g);
    compares++;
    if (g !== e) begin
      badCount++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Channel, gain and offset seen by the converter
  task automatic chkChan();
    logic [8:0] o;
    if (!regModel[0][5])
      ch = regModel[1][6] ? 0 : regModel[1][5] ? 1 : regModel[1][4] ? 2 : 0;
    o = regModel[5 + ch];
    o = o[8] ? -{1'b0, o[7:0]} : {1'b0, o[7:0]};
    chkReg({1'b0, ch[1:0], regModel[2 + ch][5:0]}, {1'b0, activeChan,
      chanGain});
    chkReg(o, chanOffset);
  endtask

  // Pulses drop first: the model does not track the sequencer here
  task automatic put(int a, logic [8:0] v);
    secondSampleClock = 1'b0;
    converterClockFall = 1'b0;
    host.writeReg(a[2:0], v);
    regModel[a] = v & wmask(a);
    chkReg({4'h0, regModel[0][6:2]}, {4'h0, modePins});
    chkChan();
  endtask

  // Sampling pulses stay up between steps to avoid double assignment
  task automatic step(bit s, bit f);
    secondSampleClock = s;
    converterClockFall = f;
    if (regModel[0][5] && !regModel[0][2]) begin
      if (s) ch = regModel[1][7] ? 0 : 2;
      else if (f) ch = regModel[1][7] ? (ch + 1) % 3 : (ch + 2) % 3;
    end
    @(negedge sys_clk);
    chkChan();
  endtask

  task automatic completeRun();
    $display("compares=%0d badCount=%0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    bit [31:0] r;
    rst_n = 1'b0;
    secondSampleClock = 1'b0;
    converterClockFall = 1'b0;
    ch = 0;
    for (int i = 0; i < 8; i++)
      regModel[i] = (i == 0) ? 9'h078 : (i == 1) ? 9'h0C0 : 9'h000;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      host.readReg(i[2:0], d);
      chkReg(regModel[i], d);
    end
    chkChan();
    // Random words with reserved bits set on purpose
    for (int i = 0; i < 24; i++) begin
      put(i % 8, 9'(rnd()));
      host.readReg(3'(i % 8), d);
      chkReg(regModel[i % 8], d);
    end
    put(5, 9'h1FF);
    put(6, 9'h100);
    put(7, 9'h07F);
    put(2, 9'h03F);
    // Sequencer in each mode and order, random pulse pattern
    foreach (cfg[k]) begin
      put(0, cfg[k][17:9]);
      put(1, cfg[k][8:0]);
      for (int n = 0; n < 12; n++) begin
        r = rnd();
        step(r[1:0] == 2'b00, r[2]);
      end
    end
    secondSampleClock = 1'b0;
    converterClockFall = 1'b0;
    @(negedge sys_clk);
    completeRun();
  end
endmodule // imager_afe_control_registers_test
